// ---- hdl/tunnel_pkg.sv ----
package tunnel_pkg;
   localparam logic [7:0] CMD_QUERY = 8'h28;
   localparam logic [7:0] CMD_ANSWER_OK = 8'hF8;
   localparam logic [7:0] CMD_ANSWER_ERR = 8'hE8;
   localparam logic [7:0] RF_READ_BLOCK = 8'h06;
   localparam logic [7:0] RF_READ_APDU = 8'hB0;
   localparam logic [7:0] RF_WRITE_BLOCK = 8'h08;
   localparam logic [7:0] RF_WRITE_APDU = 8'hD6;
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] STATUS_ERR = 8'h01;
   localparam logic [7:0] STATUS_REJECT = 8'h02;
   localparam int ADDR_BIT_FIXED0 = 7;
   localparam int ADDR_BIT_TUNNEL = 6;
   localparam int ADDR_SUBMODE_HI = 5;
   localparam int ADDR_SUBMODE_LO = 4;
   localparam int BLOCK_TUNNEL_BIT = 15;
   localparam int APDU_TUNNEL_BIT = 7;
   localparam logic [1:0] SUBMODE_READ = 2'h0;
   localparam logic [1:0] SUBMODE_WRITE = 2'h2;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int WAIT_WIDTH = 24;
   localparam int CLOCK_HZ = 20000000;
   localparam int WAIT_TICK_US = 1;
   localparam int WAIT_TICK_CYCLES = (CLOCK_HZ / 1000000) * WAIT_TICK_US;
   localparam logic [7:0] IRQ_SOURCE_SELECT_RESET = 8'h00;
   localparam logic [WAIT_WIDTH-1:0] WAIT_RESET = 24'h000000;
endpackage

// ---- hdl/sync_2ff.sv ----
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge clock) begin
      if (srst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/stream_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   input wire logic flush
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] count_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_reg];
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end
   always_ff @(posedge clock) begin
      if (srst || flush) begin
         wr_reg <= '0;
         rd_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
         count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule
`default_nettype wire

// ---- hdl/rf_to_host_tunnel_relay.sv ----
`timescale 1ns/10ps
`default_nettype none
module rf_to_host_tunnel_relay (
   input wire logic clock,
   input wire logic srst,
   // Reader side, already decoded frame fields
   input wire logic rf_cmd_valid,
   input wire logic rf_protocol_apdu,
   input wire logic [7:0] rf_cmd_code,
   input wire logic [15:0] rf_address,
   input wire logic [7:0] rf_length,
   output logic rf_resp_start,
   output logic rf_resp_error,
   output logic rf_resp_valid,
   input wire logic rf_resp_ready,
   output logic [7:0] rf_resp_data,
   output logic rf_resp_last,
   // Host serial side, byte level
   input wire logic host_addr_ack,
   input wire logic host_addr_read,
   input wire logic host_cmd_valid,
   input wire logic [7:0] host_cmd_code,
   input wire logic host_data_valid,
   output logic host_data_ready,
   input wire logic [7:0] host_data,
   input wire logic host_data_last,
   output logic host_resp_valid,
   output logic [7:0] host_resp_status,
   output logic [15:0] host_resp_address,
   output logic [7:0] host_resp_length,
   input wire logic host_resp_done,
   input wire logic host_other_done,
   // Interrupt pin and sources, wait limits and status
   output logic host_irq_out_n,
   input wire logic [7:0] irq_source_select,
   input wire logic [3:0] other_irq_events,
   input wire logic external_supply,
   input wire logic [23:0] inquiry_wait_limit,
   input wire logic [23:0] report_wait_limit,
   output logic tunnel_busy,
   output logic wait_timeout
);
   typedef enum {
      ST_IDLE,
      ST_WAIT_QUERY,
      ST_QUERY_RESP,
      ST_WAIT_ANSWER,
      ST_ANSWER_DATA,
      ST_ANSWER_RESP,
      ST_RF_RESP
   } tunnel_state_e;

   tunnel_state_e state_reg;
   tunnel_state_e state_next;
   logic irq_reg;
   logic irq_next;
   logic other_pending_reg;
   logic other_busy_reg;
   logic [15:0] pend_addr_reg;
   logic [7:0] pend_len_reg;
   logic [1:0] pend_mode_reg;
   logic answer_err_reg;
   logic [23:0] wait_cnt_reg;
   logic [4:0] tick_cnt_reg;
   logic [7:0] resp_status_reg;
   logic timeout_reg;
   logic [7:0] rf_len_reg;
   logic [3:0] other_sync;
   logic supply_sync;

   sync_2ff #(.WIDTH(5)) u_sync (
      .clock(clock),
      .srst(srst),
      .async_in({external_supply, other_irq_events}),
      .sync_out({supply_sync, other_sync})
   );

   wire is_read_cmd = (rf_cmd_code == tunnel_pkg::RF_READ_BLOCK) ||
                      (rf_cmd_code == tunnel_pkg::RF_READ_APDU);
   wire is_write_cmd = (rf_cmd_code == tunnel_pkg::RF_WRITE_BLOCK) ||
                       (rf_cmd_code == tunnel_pkg::RF_WRITE_APDU);
   wire proto_ok = rf_protocol_apdu ? (rf_cmd_code[7] == 1'b1) : (rf_cmd_code[7] == 1'b0);
   wire tunnel_flag = rf_protocol_apdu ? rf_address[tunnel_pkg::APDU_TUNNEL_BIT + 8]
                                       : rf_address[tunnel_pkg::BLOCK_TUNNEL_BIT];
   wire tunnel_cmd = rf_cmd_valid && proto_ok && tunnel_flag && (is_read_cmd || is_write_cmd);
   wire tunnel_accept = tunnel_cmd && (state_reg == ST_IDLE);

   wire in_tunnel = (state_reg != ST_IDLE);
   wire is_query = host_cmd_valid && (host_cmd_code == tunnel_pkg::CMD_QUERY);
   wire is_answer = host_cmd_valid && ((host_cmd_code == tunnel_pkg::CMD_ANSWER_OK) ||
                    (host_cmd_code == tunnel_pkg::CMD_ANSWER_ERR));
   wire query_take = is_query && (state_reg == ST_WAIT_QUERY);
   wire answer_take = is_answer && (state_reg == ST_WAIT_ANSWER);
   wire tunnel_only_reject = host_cmd_valid && (is_query || is_answer) && !query_take &&
                             !answer_take;
   wire other_cmd = host_cmd_valid && !is_query && !is_answer;
   wire waiting = (state_reg == ST_WAIT_QUERY) || (state_reg == ST_WAIT_ANSWER);
   wire wait_paused = other_busy_reg || other_pending_reg || other_cmd;
   wire tick = (tick_cnt_reg == 5'(tunnel_pkg::WAIT_TICK_CYCLES - 1));
   wire [23:0] wait_limit = (state_reg == ST_WAIT_QUERY) ? inquiry_wait_limit
                                                         : report_wait_limit;
   wire timeout_hit = waiting && !wait_paused && tick && (wait_cnt_reg >= wait_limit) &&
                      (wait_limit != '0);
   wire irq_release = host_addr_ack && host_addr_read;
   wire [3:0] other_selected = other_sync & irq_source_select[3:0];
   wire other_irq_set = (|other_selected) && supply_sync;

   // Report data goes through the FIFO toward the reader
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   wire fifo_push = (state_reg == ST_ANSWER_DATA) && host_data_valid;
   wire rf_draining = (state_reg == ST_RF_RESP) && !answer_err_reg;
   assign host_data_ready = (state_reg == ST_ANSWER_DATA) && fifo_in_ready;

   stream_fifo #(.WIDTH(tunnel_pkg::FIFO_WIDTH), .DEPTH(tunnel_pkg::FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .srst(srst),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(host_data),
      .out_valid(fifo_out_valid),
      .out_ready(rf_draining && rf_resp_ready),
      .out_data(fifo_out_data),
      .flush(state_reg == ST_IDLE)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (tunnel_accept) begin
               state_next = ST_WAIT_QUERY;
            end
         end
         ST_WAIT_QUERY: begin
            if (timeout_hit) begin
               state_next = ST_IDLE;
            end else if (query_take) begin
               state_next = ST_QUERY_RESP;
            end
         end
         ST_QUERY_RESP: begin
            if (host_resp_done) begin
               state_next = ST_WAIT_ANSWER;
            end
         end
         ST_WAIT_ANSWER: begin
            if (timeout_hit) begin
               state_next = ST_IDLE;
            end else if (answer_take) begin
               state_next = (host_cmd_code == tunnel_pkg::CMD_ANSWER_ERR) ? ST_ANSWER_RESP
                                                                          : ST_ANSWER_DATA;
            end
         end
         ST_ANSWER_DATA: begin
            if (host_data_valid && host_data_ready && host_data_last) begin
               state_next = ST_ANSWER_RESP;
            end
         end
         ST_ANSWER_RESP: begin
            if (host_resp_done) begin
               state_next = ST_RF_RESP;
            end
         end
         ST_RF_RESP: begin
            if (answer_err_reg || (rf_resp_ready && (!fifo_out_valid || rf_resp_last))) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_comb begin
      irq_next = irq_reg;
      if (tunnel_accept || other_irq_set) begin
         irq_next = 1'b1;
      end else if (irq_release) begin
         irq_next = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         irq_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         irq_reg <= irq_next;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pend_addr_reg <= '0;
         pend_len_reg <= '0;
         pend_mode_reg <= '0;
      end else if (tunnel_accept) begin
         pend_addr_reg <= rf_address;
         pend_len_reg <= rf_length;
         pend_mode_reg <= is_write_cmd ? tunnel_pkg::SUBMODE_WRITE : tunnel_pkg::SUBMODE_READ;
      end
   end

   // Wait timer restarts on every state change into a wait state
   always_ff @(posedge clock) begin
      if (srst || !waiting || (state_next != state_reg)) begin
         wait_cnt_reg <= tunnel_pkg::WAIT_RESET;
         tick_cnt_reg <= '0;
      end else if (!wait_paused) begin
         tick_cnt_reg <= tick ? 5'h00 : tick_cnt_reg + 5'h01;
         if (tick && (wait_cnt_reg != 24'hFFFFFF)) begin
            wait_cnt_reg <= wait_cnt_reg + 24'h000001;
         end
      end
   end

   // Unrelated command holds from address acknowledge to its reply
   always_ff @(posedge clock) begin
      if (srst) begin
         other_busy_reg <= 1'b0;
         other_pending_reg <= 1'b0;
      end else begin
         if (other_cmd) begin
            other_busy_reg <= 1'b1;
         end else if (host_other_done) begin
            other_busy_reg <= 1'b0;
         end
         if (host_addr_ack && !host_addr_read && waiting) begin
            other_pending_reg <= 1'b1;
         end else if (host_cmd_valid || host_other_done) begin
            other_pending_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         answer_err_reg <= 1'b0;
         resp_status_reg <= tunnel_pkg::STATUS_OK;
         timeout_reg <= 1'b0;
         rf_len_reg <= '0;
      end else begin
         if (answer_take) begin
            answer_err_reg <= (host_cmd_code == tunnel_pkg::CMD_ANSWER_ERR);
            resp_status_reg <= (host_cmd_code == tunnel_pkg::CMD_ANSWER_ERR) ?
                               tunnel_pkg::STATUS_ERR : tunnel_pkg::STATUS_OK;
         end else if (query_take) begin
            resp_status_reg <= tunnel_pkg::STATUS_OK;
         end else if (tunnel_only_reject) begin
            resp_status_reg <= tunnel_pkg::STATUS_REJECT;
         end
         if (timeout_hit) begin
            timeout_reg <= 1'b1;
         end else if (tunnel_accept) begin
            timeout_reg <= 1'b0;
         end
         if (state_reg == ST_ANSWER_RESP) begin
            rf_len_reg <= pend_len_reg;
         end else if (rf_draining && rf_resp_ready && fifo_out_valid) begin
            rf_len_reg <= rf_len_reg - 8'h01;
         end
      end
   end

   assign host_irq_out_n = ~irq_reg;
   assign tunnel_busy = in_tunnel;
   assign wait_timeout = timeout_reg;
   assign host_resp_valid = (state_reg == ST_QUERY_RESP) || (state_reg == ST_ANSWER_RESP);
   assign host_resp_status = resp_status_reg;
   assign host_resp_address = {1'b0, 1'b1, pend_mode_reg, pend_addr_reg[11:0]};
   assign host_resp_length = pend_len_reg;
   assign rf_resp_start = (state_reg == ST_ANSWER_RESP) && host_resp_done;
   assign rf_resp_error = answer_err_reg;
   assign rf_resp_valid = rf_draining && fifo_out_valid;
   assign rf_resp_data = fifo_out_data;
   assign rf_resp_last = rf_draining && (rf_len_reg == 8'h01);
endmodule
`default_nettype wire

// ---- testbench/relay_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module relay_asserts (
   input wire logic clock,
   input wire logic srst,
   input wire logic rf_cmd_valid,
   input wire logic rf_protocol_apdu,
   input wire logic [7:0] rf_cmd_code,
   input wire logic [15:0] rf_address,
   input wire logic rf_resp_start,
   input wire logic rf_resp_error,
   input wire logic rf_resp_valid,
   input wire logic host_addr_ack,
   input wire logic host_addr_read,
   input wire logic host_cmd_valid,
   input wire logic [7:0] host_cmd_code,
   input wire logic host_resp_valid,
   input wire logic [15:0] host_resp_address,
   input wire logic host_resp_done,
   input wire logic host_irq_out_n,
   input wire logic [7:0] irq_source_select,
   input wire logic tunnel_busy,
   input wire logic wait_timeout
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   wire logic rd_wr_code = rf_protocol_apdu ?
      (rf_cmd_code == tunnel_pkg::RF_READ_APDU || rf_cmd_code == tunnel_pkg::RF_WRITE_APDU) :
      (rf_cmd_code == tunnel_pkg::RF_READ_BLOCK || rf_cmd_code == tunnel_pkg::RF_WRITE_BLOCK);
   wire logic take_cmd = rf_cmd_valid && !tunnel_busy && rf_address[15] && rd_wr_code;
   property p_irq_raise;
      take_cmd |=> !host_irq_out_n && tunnel_busy;
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("interrupt not raised for tunnel command");
   property p_irq_release;
      host_addr_ack && host_addr_read && !rf_cmd_valid && irq_source_select[3:0] == 4'h0
         |=> host_irq_out_n;
   endproperty
   a_irq_release: assert property (p_irq_release)
      else $error("interrupt held after read address match");
   property p_addr_fixed;
      host_resp_valid |-> host_resp_address[15:14] == 2'b01;
   endproperty
   a_addr_fixed: assert property (p_addr_fixed)
      else $error("reply address top bits wrong");
   property p_submode;
      host_resp_valid |-> !host_resp_address[12];
   endproperty
   a_submode: assert property (p_submode)
      else $error("reply sub-mode uses a reserved code");
   property p_reply_holds;
      host_resp_valid && !host_resp_done |=> host_resp_valid;
   endproperty
   a_reply_holds: assert property (p_reply_holds)
      else $error("host reply dropped before done");
   property p_start_order;
      rf_resp_start |-> host_resp_done ##1 !host_resp_valid && (rf_resp_valid || rf_resp_error);
   endproperty
   a_start_order: assert property (p_start_order)
      else $error("reader response did not follow the finished status reply");
   property p_stream_order;
      $rose(rf_resp_valid) |-> !host_resp_valid;
   endproperty
   a_stream_order: assert property (p_stream_order)
      else $error("reader stream while host reply pending");
   property p_idle_query;
      host_cmd_valid && host_cmd_code == tunnel_pkg::CMD_QUERY && !tunnel_busy && !host_resp_valid
         |=> !host_resp_valid [*2];
   endproperty
   a_idle_query: assert property (p_idle_query)
      else $error("inquiry answered outside tunnel");
   property p_no_flag;
      rf_cmd_valid && !tunnel_busy && !rf_address[15] |=> !tunnel_busy;
   endproperty
   a_no_flag: assert property (p_no_flag)
      else $error("command without tunnel flag taken");
   property p_timeout_idle;
      $rose(wait_timeout) |-> !tunnel_busy;
   endproperty
   a_timeout_idle: assert property (p_timeout_idle)
      else $error("timeout left transaction pending");
   c_start: cover property (rf_resp_start);
   c_reply: cover property (host_resp_valid && host_resp_done);
   c_timeout: cover property ($rose(wait_timeout));
endmodule
bind rf_to_host_tunnel_relay relay_asserts u_asserts (.clock, .srst, .rf_cmd_valid,
   .rf_protocol_apdu, .rf_cmd_code, .rf_address, .rf_resp_start, .rf_resp_error, .rf_resp_valid,
   .host_addr_ack, .host_addr_read, .host_cmd_valid, .host_cmd_code, .host_resp_valid,
   .host_resp_address, .host_resp_done, .host_irq_out_n, .irq_source_select,
   .tunnel_busy, .wait_timeout);
`default_nettype wire

// ---- testbench/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic clock,
   input wire logic host_irq_out_n,
   input wire logic host_data_ready,
   input wire logic host_resp_valid,
   input wire logic [7:0] host_resp_status,
   input wire logic [15:0] host_resp_address,
   input wire logic [7:0] host_resp_length,
   output logic host_addr_ack = 1'b0,
   output logic host_addr_read = 1'b0,
   output logic host_cmd_valid = 1'b0,
   output logic [7:0] host_cmd_code = 8'h00,
   output logic host_data_valid = 1'b0,
   output logic [7:0] host_data = 8'h5A,
   output logic host_data_last = 1'b0,
   output logic host_resp_done = 1'b0,
   output logic host_other_done = 1'b0,
   output logic external_supply = 1'b0
);
   always @(posedge clock) if (!host_irq_out_n) external_supply <= 1'b1;
   task automatic addr(input logic rd);
      @(posedge clock);
      host_addr_ack <= 1'b1;
      host_addr_read <= rd;
      @(posedge clock);
      host_addr_ack <= 1'b0;
      host_addr_read <= 1'b0;
   endtask
   // Address acknowledge always precedes the command byte
   task automatic cmd(input logic [7:0] code);
      addr(1'b0);
      host_cmd_valid <= 1'b1;
      host_cmd_code <= code;
      @(posedge clock);
      host_cmd_valid <= 1'b0;
      host_cmd_code <= ~code;
   endtask
   task automatic send(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         repeat (gap + 1) @(posedge clock);
         host_data_valid <= 1'b1;
         host_data <= 8'hA0 + 8'(i);
         host_data_last <= (i == n - 1);
         @(posedge clock);
         while (host_data_ready !== 1'b1) @(posedge clock);
         host_data_valid <= 1'b0;
         host_data <= ~host_data;
         host_data_last <= 1'b0;
      end
   endtask
   task automatic fetch(output logic [7:0] st, output logic [15:0] ad, output logic [7:0] ln);
      @(posedge clock);
      while (host_resp_valid !== 1'b1) @(posedge clock);
      st = host_resp_status;
      ad = host_resp_address;
      ln = host_resp_length;
      host_resp_done <= 1'b1;
      @(posedge clock);
      host_resp_done <= 1'b0;
   endtask
   task automatic other(input int hold);
      cmd(8'h10);
      repeat (hold) @(posedge clock);
      host_other_done <= 1'b1;
      @(posedge clock);
      host_other_done <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- testbench/rf_to_host_tunnel_relay_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin fails++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
module rf_to_host_tunnel_relay_tb;
   logic clock = 1'b0, srst = 1'b1, rf_cmd_valid = 1'b0, rf_protocol_apdu = 1'b0;
   logic rf_resp_ready = 1'b0, start_seen = 1'b0;
   logic [7:0] rf_cmd_code = 8'h00, rf_length = 8'h00, irq_source_select = 8'h00, st, ln;
   logic [15:0] rf_address = 16'h0000, ra;
   logic [3:0] other_irq_events = 4'h0;
   logic [23:0] inquiry_wait_limit = 24'h0003E8, report_wait_limit = 24'h0003E8;
   logic rf_resp_start, rf_resp_error, rf_resp_valid, rf_resp_last, host_data_ready;
   logic host_resp_valid, host_irq_out_n, tunnel_busy, wait_timeout, host_addr_ack;
   logic host_addr_read, host_cmd_valid, host_data_valid, host_data_last, host_resp_done;
   logic host_other_done, external_supply;
   logic [7:0] rf_resp_data, host_resp_status, host_resp_length, host_cmd_code, host_data;
   logic [15:0] host_resp_address;
   int fails = 0, check_count = 0;
   always #25 clock = ~clock;
   always @(posedge clock) if (rf_resp_start === 1'b1) start_seen <= 1'b1;
   rf_to_host_tunnel_relay DUT (.clock, .srst, .rf_cmd_valid, .rf_protocol_apdu, .rf_cmd_code,
      .rf_address, .rf_length, .rf_resp_start, .rf_resp_error, .rf_resp_valid, .rf_resp_ready,
      .rf_resp_data, .rf_resp_last, .host_addr_ack, .host_addr_read, .host_cmd_valid,
      .host_cmd_code, .host_data_valid, .host_data_ready, .host_data, .host_data_last,
      .host_resp_valid, .host_resp_status, .host_resp_address, .host_resp_length,
      .host_resp_done, .host_other_done, .host_irq_out_n, .irq_source_select, .other_irq_events,
      .external_supply, .inquiry_wait_limit, .report_wait_limit, .tunnel_busy, .wait_timeout);
   host_model host (.clock, .host_irq_out_n, .host_data_ready, .host_resp_valid,
      .host_resp_status, .host_resp_address, .host_resp_length, .host_addr_ack,
      .host_addr_read, .host_cmd_valid, .host_cmd_code, .host_data_valid, .host_data,
      .host_data_last, .host_resp_done, .host_other_done, .external_supply);
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic rf_cmd(input logic apdu, input logic [7:0] code, input logic [15:0] ad,
         input logic [7:0] n);
      @(posedge clock);
      rf_cmd_valid <= 1'b1;
      rf_protocol_apdu <= apdu;
      rf_cmd_code <= code;
      rf_address <= ad;
      rf_length <= n;
      @(posedge clock);
      rf_cmd_valid <= 1'b0;
      rf_address <= ~ad;
      #1;
   endtask
   task automatic wait_to(input int lim);
      for (int i = 0; i < lim && wait_timeout !== 1'b1; i++) @(posedge clock);
      #1;
   endtask
   task automatic tunnel(input logic apdu, input logic [7:0] code, input logic [15:0] ad,
         input int n, input logic ok, input int gap);
      logic [1:0] md;
      int got, nx;
      md = (code == tunnel_pkg::RF_WRITE_BLOCK || code == tunnel_pkg::RF_WRITE_APDU) ?
         tunnel_pkg::SUBMODE_WRITE : tunnel_pkg::SUBMODE_READ;
      nx = ok ? n : 0;
      got = 0;
      start_seen <= 1'b0;
      rf_cmd(apdu, code, ad, 8'(n));
      `CHK("irq_low", 1'b0, host_irq_out_n)
      host.addr(1'b1);
      #1 `CHK("irq_released", 1'b1, host_irq_out_n)
      host.cmd(tunnel_pkg::CMD_QUERY);
      host.fetch(st, ra, ln);
      `CHK("query_status", tunnel_pkg::STATUS_OK, st)
      `CHK("query_address", {2'b01, md, ad[11:0]}, ra)
      `CHK("query_length", 8'(n), ln)
      host.cmd(ok ? tunnel_pkg::CMD_ANSWER_OK : tunnel_pkg::CMD_ANSWER_ERR);
      if (ok) host.send(n, gap);
      #1 `CHK("early_start", 1'b0, start_seen)
      host.fetch(st, ra, ln);
      `CHK("report_status", ok ? tunnel_pkg::STATUS_OK : tunnel_pkg::STATUS_ERR, st)
      #1 `CHK("start_seen", 1'b1, start_seen)
      `CHK("rf_error", ~ok, rf_resp_error)
      repeat (3) @(posedge clock);
      rf_resp_ready <= ok;
      for (int c = 0; c < 100 && got < nx; c++) begin
         @(posedge clock);
         if (rf_resp_valid === 1'b1) begin
            `CHK("rf_data", 8'hA0 + 8'(got), rf_resp_data)
            `CHK("rf_last", got == n - 1, rf_resp_last)
            got++;
         end
      end
      if (ok) rf_resp_ready <= 1'b0;
      `CHK("rf_count", nx, got)
      repeat (2) @(posedge clock);
      #1 `CHK("idle_after", 1'b0, tunnel_busy)
   endtask
   initial begin
      repeat (30000) @(posedge clock);
      fails++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      #1 `CHK("reset_irq", 1'b1, host_irq_out_n)
      tunnel(1'b0, tunnel_pkg::RF_READ_BLOCK, 16'h8123, 16, 1'b1, 0);
      tunnel(1'b1, tunnel_pkg::RF_WRITE_APDU, 16'h8A05, 1, 1'b1, 3);
      tunnel(1'b0, tunnel_pkg::RF_WRITE_BLOCK, 16'hFFF0, 2, 1'b1, 1);
      tunnel(1'b1, tunnel_pkg::RF_READ_APDU, 16'h80FF, 3, 1'b0, 0);
      rf_cmd(1'b0, tunnel_pkg::RF_READ_BLOCK, 16'h7FFF, 8'h04);
      `CHK("no_flag_block", 1'b0, tunnel_busy)
      rf_cmd(1'b1, tunnel_pkg::RF_WRITE_APDU, 16'h7F00, 8'h04);
      `CHK("no_flag_apdu", 1'b1, host_irq_out_n)
      host.cmd(tunnel_pkg::CMD_QUERY);
      repeat (2) @(posedge clock);
      #1 `CHK("idle_query", 1'b0, host_resp_valid)
      `CHK("reject_status", tunnel_pkg::STATUS_REJECT, host_resp_status)
      inquiry_wait_limit <= 24'h000005;
      rf_cmd(1'b0, tunnel_pkg::RF_READ_BLOCK, 16'h8001, 8'h01);
      host.other(150);
      repeat (50) @(posedge clock);
      #1 `CHK("paused_wait", 1'b0, wait_timeout)
      wait_to(100);
      `CHK("query_timeout", 1'b1, wait_timeout)
      `CHK("timeout_idle", 1'b0, tunnel_busy)
      host.addr(1'b1);
      inquiry_wait_limit <= 24'h0003E8;
      report_wait_limit <= 24'h000005;
      rf_cmd(1'b1, tunnel_pkg::RF_READ_APDU, 16'h8010, 8'h02);
      host.addr(1'b1);
      host.cmd(tunnel_pkg::CMD_QUERY);
      host.fetch(st, ra, ln);
      repeat (60) @(posedge clock);
      #1 `CHK("report_wait", 1'b0, wait_timeout)
      wait_to(100);
      `CHK("report_timeout", 1'b1, wait_timeout)
      host.cmd(tunnel_pkg::CMD_ANSWER_OK);
      repeat (2) @(posedge clock);
      #1 `CHK("late_report", 1'b0, host_resp_valid)
      irq_source_select <= 8'h01;
      other_irq_events <= 4'h1;
      repeat (6) @(posedge clock);
      #1 `CHK("other_irq", 1'b0, host_irq_out_n)
      other_irq_events <= 4'h0;
      irq_source_select <= 8'h00;
      repeat (4) @(posedge clock);
      host.addr(1'b1);
      #1 `CHK("other_release", 1'b1, host_irq_out_n)
      conclude();
   end
endmodule
`default_nettype wire
